// ### airq_host_model.sv
`timescale 1ns/10ps

// Host side: register bus master plus a GPIO edge watcher
module airq_host_model (
  input wire logic mclk_i,
  input wire logic pin_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  int edges = 0;
  logic pin_q = 1'b0;

  // GPIO sees every level change of the request pin
  always @(posedge mclk_i) begin
    pin_q <= pin_i;
    if (pin_i !== pin_q) edges <= edges + 1;
  end

  // Bus idle at time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // One-cycle write; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr

  // One-cycle read; a read of the release place clears a latch
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd
endmodule : airq_host_model

// ### airq_pin_logic.sv
`timescale 1ns/10ps

// Condition must hold for limit samples before one fire
module airq_persist (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input wire logic en_i,
  input wire logic cond_i,
  input wire logic [7:0] limit_i,
  output logic fire_o
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic done_reg;
  logic done_next;
  logic last;

  // Sample counter, one step per data rate tick
  always_comb begin
    cnt_next = cnt_reg;
    done_next = done_reg;
    fire_o = 1'b0;
    last = ({1'b0, cnt_reg} + 9'h001) >= {1'b0, limit_i};
    if (!en_i) begin
      cnt_next = 8'h00;
      done_next = 1'b0;
    end else if (tick_i) begin
      if (!cond_i) begin
        cnt_next = 8'h00;
        done_next = 1'b0;
      end else if (!done_reg) begin
        if (last) begin
          fire_o = 1'b1;
          done_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end
endmodule : airq_persist

module airq_pin_logic (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic tilt_tick_i,
  input wire logic [5:0] tilt_pos_i,
  input wire logic wake_tick_i,
  input wire logic [5:0] wake_above_i,
  input wire logic tap_tick_i,
  input wire logic [1:0] tap_kind_i,
  input wire logic [5:0] tap_dir_i,
  input wire logic fall_tick_i,
  input wire logic fall_below_i,
  output logic [7:0] fall_threshold_o,
  output logic request_pin_one_o
);
  logic [7:0] ctrl_one_reg, ctrl_one_next;
  logic [7:0] ctrl_two_reg, ctrl_two_next;
  logic [7:0] pin_ctrl_reg, pin_ctrl_next;
  logic [7:0] irq_two_reg, irq_two_next;
  logic [7:0] irq_three_reg, irq_three_next;
  logic [7:0] route_reg, route_next;
  logic [7:0] tilt_tmr_reg, tilt_tmr_next;
  logic [7:0] wake_tmr_reg, wake_tmr_next;
  logic [7:0] fall_th_reg, fall_th_next;
  logic [7:0] fall_dly_reg, fall_dly_next;
  logic [7:0] fall_ctl_reg, fall_ctl_next;
  logic [7:0] src_one_reg, src_one_next;
  logic [7:0] src_two_reg, src_two_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [5:0] cand_reg, cand_next;
  logic [5:0] cur_reg, cur_next;
  logic [10:0] pcnt_reg, pcnt_next;
  logic pin_reg, pin_next;
  airq_pkg::airq_pin_state_t pst_reg, pst_next;
  logic [5:0] tilt_m;
  logic tilt_fire, wake_fire, tap_fire, fall_fire;
  logic [7:0] ev, route_map;
  logic rel_rd, route_new, pin_en, pol, latch_sel;

  assign pin_en = pin_ctrl_reg[airq_pkg::PIN_EN_BIT];
  assign pol = pin_ctrl_reg[airq_pkg::POL_BIT];
  assign latch_sel = pin_ctrl_reg[airq_pkg::LATCH_SEL_BIT];
  assign rel_rd = reg_rd_i && (reg_addr_i == airq_pkg::ADDR_RELEASE);
  assign reg_rdata_o = rdata_reg;
  assign fall_threshold_o = fall_th_reg;
  assign request_pin_one_o = pin_reg;

  // Tilt position masked by control two, tracked per sample
  assign tilt_m = tilt_pos_i & ctrl_two_reg[5:0];
  assign cand_next = tilt_tick_i ? tilt_m : cand_reg;
  assign cur_next = tilt_fire ? cand_reg : cur_reg;

  airq_persist u_tilt (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .tick_i(tilt_tick_i),
    .en_i(ctrl_one_reg[airq_pkg::TILT_ON_BIT]),
    .cond_i((tilt_m == cand_reg) && (tilt_m != cur_reg) && (|tilt_m)),
    .limit_i(tilt_tmr_reg),
    .fire_o(tilt_fire)
  );

  airq_persist u_wake (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .tick_i(wake_tick_i),
    .en_i(ctrl_one_reg[airq_pkg::WAKE_ON_BIT]),
    .cond_i(|(wake_above_i & irq_two_reg[5:0])),
    .limit_i(wake_tmr_reg),
    .fire_o(wake_fire)
  );

  airq_persist u_fall (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .tick_i(fall_tick_i),
    .en_i(fall_ctl_reg[airq_pkg::FALL_ON_BIT]),
    .cond_i(fall_below_i),
    .limit_i(fall_dly_reg),
    .fire_o(fall_fire)
  );

  // Tap result accepted on its own sample tick, gated by masks
  assign tap_fire = tap_tick_i && ctrl_one_reg[airq_pkg::TAP_ON_BIT]
    && (|tap_kind_i) && (|(tap_dir_i & irq_three_reg[5:0]));

  // Engine events in source two layout
  always_comb begin
    ev = 8'h00;
    ev[airq_pkg::SRC_TILT_BIT] = tilt_fire;
    ev[airq_pkg::SRC_WAKE_BIT] = wake_fire;
    ev[airq_pkg::SRC_TAP_S_BIT] = tap_fire && tap_kind_i[0];
    ev[airq_pkg::SRC_TAP_D_BIT] = tap_fire && tap_kind_i[1];
    ev[airq_pkg::SRC_FALL_BIT] = fall_fire;
    route_map = 8'h00;
    route_map[airq_pkg::SRC_TILT_BIT] = route_reg[airq_pkg::SRC_TILT_BIT];
    route_map[airq_pkg::SRC_WAKE_BIT] = route_reg[airq_pkg::SRC_WAKE_BIT];
    route_map[airq_pkg::SRC_TAP_S_BIT] = route_reg[airq_pkg::SRC_TAP_S_BIT];
    route_map[airq_pkg::SRC_TAP_D_BIT] = route_reg[airq_pkg::SRC_TAP_S_BIT];
    route_map[airq_pkg::SRC_FALL_BIT] = route_reg[airq_pkg::SRC_FALL_BIT];
    route_new = |(ev & route_map);
  end

  // Register writes, source capture and read data
  always_comb begin
    ctrl_one_next = ctrl_one_reg;
    ctrl_two_next = ctrl_two_reg;
    pin_ctrl_next = pin_ctrl_reg;
    irq_two_next = irq_two_reg;
    irq_three_next = irq_three_reg;
    route_next = route_reg;
    tilt_tmr_next = tilt_tmr_reg;
    wake_tmr_next = wake_tmr_reg;
    fall_th_next = fall_th_reg;
    fall_dly_next = fall_dly_reg;
    fall_ctl_next = fall_ctl_reg;
    if (reg_wr_i) begin
      case (reg_addr_i)
        airq_pkg::ADDR_CTRL_ONE: ctrl_one_next = reg_wdata_i;
        airq_pkg::ADDR_CTRL_TWO: ctrl_two_next = reg_wdata_i;
        airq_pkg::ADDR_PIN_CTRL: pin_ctrl_next = reg_wdata_i;
        airq_pkg::ADDR_IRQ_TWO: irq_two_next = reg_wdata_i;
        airq_pkg::ADDR_IRQ_THREE: irq_three_next = reg_wdata_i;
        airq_pkg::ADDR_ROUTING: route_next = reg_wdata_i;
        airq_pkg::ADDR_TILT_TIMER: tilt_tmr_next = reg_wdata_i;
        airq_pkg::ADDR_WAKE_TIMER: wake_tmr_next = reg_wdata_i;
        airq_pkg::ADDR_FALL_THRESH: fall_th_next = reg_wdata_i;
        airq_pkg::ADDR_FALL_DELAY: fall_dly_next = reg_wdata_i;
        airq_pkg::ADDR_FALL_CTRL: fall_ctl_next = reg_wdata_i;
        default: ;
      endcase
    end
    // Release clears, a same-cycle event still lands
    src_two_next = (rel_rd ? 8'h00 : src_two_reg) | ev;
    src_one_next = rel_rd ? 8'h00 : src_one_reg;
    if (tilt_fire) begin
      src_one_next = {2'b00, cand_reg};
    end
    rdata_next = rdata_reg;
    if (reg_rd_i) begin
      case (reg_addr_i)
        airq_pkg::ADDR_SRC_ONE: rdata_next = src_one_reg;
        airq_pkg::ADDR_SRC_TWO: rdata_next = src_two_reg;
        airq_pkg::ADDR_STATUS: rdata_next = {3'b000, |src_two_reg, 4'h0};
        airq_pkg::ADDR_CTRL_ONE: rdata_next = ctrl_one_reg;
        airq_pkg::ADDR_CTRL_TWO: rdata_next = ctrl_two_reg;
        airq_pkg::ADDR_PIN_CTRL: rdata_next = pin_ctrl_reg;
        airq_pkg::ADDR_IRQ_TWO: rdata_next = irq_two_reg;
        airq_pkg::ADDR_IRQ_THREE: rdata_next = irq_three_reg;
        airq_pkg::ADDR_ROUTING: rdata_next = route_reg;
        airq_pkg::ADDR_TILT_TIMER: rdata_next = tilt_tmr_reg;
        airq_pkg::ADDR_WAKE_TIMER: rdata_next = wake_tmr_reg;
        airq_pkg::ADDR_FALL_THRESH: rdata_next = fall_th_reg;
        airq_pkg::ADDR_FALL_DELAY: rdata_next = fall_dly_reg;
        airq_pkg::ADDR_FALL_CTRL: rdata_next = fall_ctl_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Pin state: latched until release, or one timed pulse
  always_comb begin
    pst_next = pst_reg;
    pcnt_next = pcnt_reg;
    case (pst_reg)
      airq_pkg::PIN_IDLE: begin
        if (route_new) begin
          if (latch_sel) begin
            pst_next = airq_pkg::PIN_PULSE;
            pcnt_next = 11'h000;
          end else begin
            pst_next = airq_pkg::PIN_LATCH;
          end
        end
      end
      airq_pkg::PIN_LATCH: begin
        if (rel_rd && !route_new) begin
          pst_next = airq_pkg::PIN_IDLE;
        end
      end
      airq_pkg::PIN_PULSE: begin
        if (pcnt_reg == airq_pkg::PULSE_LAST) begin
          pst_next = airq_pkg::PIN_IDLE;
        end else begin
          pcnt_next = pcnt_reg + 11'h001;
        end
      end
      default: pst_next = airq_pkg::PIN_IDLE;
    endcase
    if (!pin_en) begin
      pst_next = airq_pkg::PIN_IDLE;
      pcnt_next = 11'h000;
    end
    pin_next = (pst_next != airq_pkg::PIN_IDLE) ~^ pol;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_one_reg <= airq_pkg::CTRL_RST;
      ctrl_two_reg <= airq_pkg::MASK_RST;
      pin_ctrl_reg <= airq_pkg::PIN_CTRL_RST;
      irq_two_reg <= airq_pkg::MASK_RST;
      irq_three_reg <= airq_pkg::MASK_RST;
      route_reg <= airq_pkg::CTRL_RST;
      tilt_tmr_reg <= airq_pkg::TIMER_RST;
      wake_tmr_reg <= airq_pkg::TIMER_RST;
      fall_th_reg <= airq_pkg::TIMER_RST;
      fall_dly_reg <= airq_pkg::TIMER_RST;
      fall_ctl_reg <= airq_pkg::CTRL_RST;
      src_one_reg <= 8'h00;
      src_two_reg <= 8'h00;
      rdata_reg <= 8'h00;
      cand_reg <= 6'h00;
      cur_reg <= 6'h00;
      pcnt_reg <= 11'h000;
      pin_reg <= airq_pkg::PIN_RST_LEVEL;
      pst_reg <= airq_pkg::PIN_IDLE;
    end else begin
      ctrl_one_reg <= ctrl_one_next;
      ctrl_two_reg <= ctrl_two_next;
      pin_ctrl_reg <= pin_ctrl_next;
      irq_two_reg <= irq_two_next;
      irq_three_reg <= irq_three_next;
      route_reg <= route_next;
      tilt_tmr_reg <= tilt_tmr_next;
      wake_tmr_reg <= wake_tmr_next;
      fall_th_reg <= fall_th_next;
      fall_dly_reg <= fall_dly_next;
      fall_ctl_reg <= fall_ctl_next;
      src_one_reg <= src_one_next;
      src_two_reg <= src_two_next;
      rdata_reg <= rdata_next;
      cand_reg <= cand_next;
      cur_reg <= cur_next;
      pcnt_reg <= pcnt_next;
      pin_reg <= pin_next;
      pst_reg <= pst_next;
    end
  end

  // Checks on the pin and source logic
  sequence s_fall_routed;
    fall_fire && route_reg[airq_pkg::SRC_FALL_BIT] && pin_en && !latch_sel
      && (pst_reg == airq_pkg::PIN_IDLE);
  endsequence
  sequence s_release_quiet;
    rel_rd && (ev == 8'h00);
  endsequence

  property p_latch_hold;
    @(posedge mclk_i) disable iff (!rstn_i)
    (pst_reg == airq_pkg::PIN_LATCH) && pin_en && !rel_rd
      && (pin_ctrl_next == pin_ctrl_reg)
      |=> (pst_reg == airq_pkg::PIN_LATCH)
      && (request_pin_one_o == pol);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched pin dropped without release");

  property p_pulse_end;
    @(posedge mclk_i) disable iff (!rstn_i)
    (pst_reg == airq_pkg::PIN_PULSE) && pin_en
      && (pcnt_reg == airq_pkg::PULSE_LAST) |=> (pst_reg == airq_pkg::PIN_IDLE);
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("pulse did not end at its length");

  property p_pulse_bound;
    @(posedge mclk_i) disable iff (!rstn_i)
    (pst_reg == airq_pkg::PIN_PULSE) |-> (pcnt_reg <= airq_pkg::PULSE_LAST);
  endproperty
  a_pulse_bound: assert property (p_pulse_bound)
    else $error("pulse counter past its length");

  property p_idle_level;
    @(posedge mclk_i) disable iff (!rstn_i)
    (pst_reg == airq_pkg::PIN_IDLE) && $stable(pol)
      |-> (request_pin_one_o == !pol);
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("idle pin level disagrees with polarity");

  property p_disable;
    @(posedge mclk_i) disable iff (!rstn_i)
    !pin_en && !pin_ctrl_next[airq_pkg::PIN_EN_BIT]
      |=> (pst_reg == airq_pkg::PIN_IDLE) [*2];
  endproperty
  a_disable: assert property (p_disable)
    else $error("request shown while pin disabled");

  property p_release_clear;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_release_quiet |=> (src_two_reg == 8'h00) && (src_one_reg == 8'h00);
  endproperty
  a_release_clear: assert property (p_release_clear)
    else $error("release read left a source set");

  property p_pending_set;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ev != 8'h00) |=> ((src_two_reg & $past(ev)) == $past(ev));
  endproperty
  a_pending_set: assert property (p_pending_set)
    else $error("engine event lost from source two");

  property p_tilt_gate;
    @(posedge mclk_i) disable iff (!rstn_i)
    (tilt_fire || wake_fire || tap_fire)
      |-> (!tilt_fire || ctrl_one_reg[airq_pkg::TILT_ON_BIT])
      && (!wake_fire || ctrl_one_reg[airq_pkg::WAKE_ON_BIT])
      && (!tap_fire || ctrl_one_reg[airq_pkg::TAP_ON_BIT]);
  endproperty
  a_tilt_gate: assert property (p_tilt_gate)
    else $error("engine fired while disabled");

  property p_fall_gate;
    @(posedge mclk_i) disable iff (!rstn_i)
    fall_fire |-> fall_ctl_reg[airq_pkg::FALL_ON_BIT] && fall_tick_i
      && fall_below_i;
  endproperty
  a_fall_gate: assert property (p_fall_gate)
    else $error("fall request without enable or condition");

  property p_wake_mask;
    @(posedge mclk_i) disable iff (!rstn_i)
    wake_fire |-> wake_tick_i && (|(wake_above_i & irq_two_reg[5:0]));
  endproperty
  a_wake_mask: assert property (p_wake_mask)
    else $error("wake request on masked axis or off tick");

  property p_route_fall;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_fall_routed |=> (pst_reg == airq_pkg::PIN_LATCH);
  endproperty
  a_route_fall: assert property (p_route_fall)
    else $error("routed fall request did not latch the pin");
endmodule : airq_pin_logic

// ### airq_pkg.sv
package airq_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_SRC_ONE = 8'h12;
  localparam logic [7:0] ADDR_SRC_TWO = 8'h13;
  localparam logic [7:0] ADDR_STATUS = 8'h15;
  localparam logic [7:0] ADDR_RELEASE = 8'h17;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h18;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h19;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_TWO = 8'h1D;
  localparam logic [7:0] ADDR_IRQ_THREE = 8'h1E;
  localparam logic [7:0] ADDR_ROUTING = 8'h1F;
  localparam logic [7:0] ADDR_TILT_TIMER = 8'h22;
  localparam logic [7:0] ADDR_WAKE_TIMER = 8'h23;
  localparam logic [7:0] ADDR_FALL_THRESH = 8'h2C;
  localparam logic [7:0] ADDR_FALL_DELAY = 8'h2D;
  localparam logic [7:0] ADDR_FALL_CTRL = 8'h2E;
  // Field positions in the pin control register
  localparam int LATCH_SEL_BIT = 3;
  localparam int POL_BIT = 4;
  localparam int PIN_EN_BIT = 5;
  // Engine enables in control one and fall control
  localparam int TILT_ON_BIT = 0;
  localparam int WAKE_ON_BIT = 1;
  localparam int TAP_ON_BIT = 2;
  localparam int FALL_ON_BIT = 7;
  // Source two layout, also the routing layout except that double tap is routed by the single tap bit; pending bit is in status
  localparam int SRC_TILT_BIT = 0;
  localparam int SRC_WAKE_BIT = 1;
  localparam int SRC_TAP_S_BIT = 2;
  localparam int SRC_TAP_D_BIT = 3;
  localparam int SRC_FALL_BIT = 7;
  localparam int PENDING_BIT = 4;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h3F;
  localparam logic [7:0] PIN_CTRL_RST = 8'h10;
  localparam logic [7:0] TIMER_RST = 8'h00;
  localparam logic PIN_RST_LEVEL = ~PIN_CTRL_RST[POL_BIT];
  // Pulse length on the request pin
  localparam int PULSE_NS = 50000;
  localparam int CLK_NS = 40;
  localparam int PULSE_CYC = PULSE_NS / CLK_NS;
  localparam logic [10:0] PULSE_LAST = 11'(PULSE_CYC - 1);
  typedef enum logic [1:0] {
    PIN_IDLE = 2'b00,
    PIN_LATCH = 2'b01,
    PIN_PULSE = 2'b10
  } airq_pin_state_t;
endpackage : airq_pkg

// ### tb.sv
`timescale 1ns/10ps

module tb;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } airq_row_t;

  logic mclk_i;
  logic rstn_i;
  logic [7:0] addr, wdata, rdata, fthr, d;
  logic wr, rd, pin;
  logic [3:0] tk;
  logic [5:0] tilt_pos, wake_above, tap_dir;
  logic [1:0] tap_kind;
  logic fall_below;
  int fail_count = 0;
  int n_checks = 0;
  int n, e;

  // Reset values, readback, unmapped and release places
  airq_row_t rows [8] = '{
    '{1'b0, 8'h1C, 8'h00, 8'h10},
    '{1'b0, 8'h19, 8'h00, 8'h3F},
    '{1'b0, 8'h1D, 8'h00, 8'h3F},
    '{1'b0, 8'h1E, 8'h00, 8'h3F},
    '{1'b1, 8'h1C, 8'h38, 8'h38},
    '{1'b1, 8'h40, 8'h5A, 8'h00},
    '{1'b1, 8'h2C, 8'h02, 8'h02},
    '{1'b0, 8'h17, 8'h00, 8'h00}};

  airq_pin_logic u_dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .tilt_tick_i(tk[0]), .tilt_pos_i(tilt_pos),
    .wake_tick_i(tk[1]), .wake_above_i(wake_above),
    .tap_tick_i(tk[2]), .tap_kind_i(tap_kind), .tap_dir_i(tap_dir),
    .fall_tick_i(tk[3]), .fall_below_i(fall_below),
    .fall_threshold_o(fthr), .request_pin_one_o(pin));

  airq_host_model u_host (
    .mclk_i(mclk_i), .pin_i(pin), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  // Clock
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // Compare and count
  task automatic chk(input string what, input logic [31:0] s,
                     input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      $display("Error %s expected %0h seen %0h", what, x, s);
      fail_count++;
    end
  endtask : chk

  // Engine sample pulses on line k
  task automatic tick(input int cnt, input int k);
    repeat (cnt) begin
      @(posedge mclk_i);
      tk[k] <= 1'b1;
      @(posedge mclk_i);
      tk[k] <= 1'b0;
    end
  endtask : tick

  task automatic settle;
    @(posedge mclk_i);
    #1;
  endtask : settle

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // Watchdog well beyond the expected run
  initial begin
    #2000000;
    fail_count++;
    final_report();
  end

  // Main sequence
  initial begin
    rstn_i = 1'b0;
    tk = 4'h0;
    tilt_pos = 6'h00;
    wake_above = 6'h00;
    tap_dir = 6'h00;
    tap_kind = 2'h0;
    fall_below = 1'b0;
    repeat (8) @(posedge mclk_i);
    rstn_i <= 1'b1;
    #1;
    chk("pin rst", pin, 1'b0);
    chk("rdata rst", rdata, 8'h00);
    foreach (rows[i]) begin
      if (rows[i].w) u_host.wr(rows[i].a, rows[i].d);
      u_host.rd(rows[i].a, d);
      chk("reg", d, rows[i].e);
    end
    chk("thr out", fthr, 8'h02);
    chk("idle low", pin, 1'b0);
    $display("test registers done");
    // Fall: off, debounce, latch, release
    u_host.wr(8'h2D, 8'h02);
    u_host.wr(8'h1C, 8'h30);
    u_host.wr(8'h1F, 8'h80);
    fall_below <= 1'b1;
    tick(2, 3);
    u_host.rd(8'h13, d);
    chk("fall off", d, 8'h00);
    u_host.wr(8'h2E, 8'h80);
    tick(1, 3);
    settle();
    chk("debounce", pin, 1'b0);
    tick(1, 3);
    settle();
    chk("latched", pin, 1'b1);
    u_host.rd(8'h13, d);
    chk("src fall", d, 8'h80);
    u_host.rd(8'h15, d);
    chk("pending", d[4], 1'b1);
    repeat (100) @(posedge mclk_i);
    #1;
    chk("held", pin, 1'b1);
    u_host.rd(8'h17, d);
    settle();
    chk("released", pin, 1'b0);
    u_host.rd(8'h13, d);
    chk("src clr", d, 8'h00);
    u_host.rd(8'h15, d);
    chk("pend clr", d[4], 1'b0);
    fall_below <= 1'b0;
    u_host.wr(8'h2E, 8'h00);
    $display("test latch done");
    // Tap in pulse mode, active low
    u_host.wr(8'h18, 8'h04);
    u_host.wr(8'h1F, 8'h04);
    u_host.wr(8'h1C, 8'h28);
    tap_kind <= 2'h1;
    tap_dir <= 6'h01;
    settle();
    chk("idle high", pin, 1'b1);
    tick(1, 2);
    n = 0;
    #1;
    repeat (1400) begin
      if (pin === 1'b0) n++;
      settle();
    end
    chk("pulse len", n, airq_pkg::PULSE_CYC);
    chk("pulse end", pin, 1'b1);
    u_host.rd(8'h13, d);
    chk("src tap", d[2], 1'b1);
    u_host.rd(8'h17, d);
    $display("test pulse done");
    // Pin disabled, then engine off
    u_host.wr(8'h1C, 8'h18);
    // Let the polarity change reach the GPIO watcher first
    settle();
    settle();
    e = u_host.edges;
    tick(1, 2);
    n = 0;
    repeat (1400) begin
      settle();
      if (pin !== 1'b0) n++;
    end
    chk("no pin", n, 0);
    chk("no edges", u_host.edges - e, 0);
    u_host.rd(8'h15, d);
    chk("poll pend", d[4], 1'b1);
    u_host.rd(8'h17, d);
    u_host.wr(8'h18, 8'h00);
    tick(1, 2);
    settle();
    u_host.rd(8'h13, d);
    chk("tap off", d, 8'h00);
    $display("test disabled done");
    // Wake: axis mask, sample-based timer
    u_host.wr(8'h18, 8'h02);
    u_host.wr(8'h23, 8'h03);
    u_host.wr(8'h1D, 8'h01);
    u_host.wr(8'h1F, 8'h02);
    u_host.wr(8'h1C, 8'h30);
    wake_above <= 6'h02;
    tick(4, 1);
    u_host.rd(8'h13, d);
    chk("masked", d, 8'h00);
    wake_above <= 6'h01;
    tick(2, 1);
    repeat (50) @(posedge mclk_i);
    u_host.rd(8'h13, d);
    chk("early", d, 8'h00);
    tick(1, 1);
    settle();
    chk("wake pin", pin, 1'b1);
    u_host.rd(8'h13, d);
    chk("src wake", d, 8'h02);
    u_host.rd(8'h17, d);
    $display("test wake done");
    // Tilt: new position must persist, then masked
    u_host.wr(8'h18, 8'h01);
    u_host.wr(8'h22, 8'h02);
    u_host.wr(8'h1F, 8'h01);
    tilt_pos <= 6'h01;
    tick(2, 0);
    u_host.rd(8'h13, d);
    chk("tilt early", d, 8'h00);
    tick(1, 0);
    settle();
    chk("tilt pin", pin, 1'b1);
    u_host.rd(8'h12, d);
    chk("tilt pos", d, 8'h01);
    u_host.rd(8'h13, d);
    chk("src tilt", d, 8'h01);
    u_host.rd(8'h17, d);
    u_host.wr(8'h19, 8'h3D);
    tilt_pos <= 6'h02;
    tick(3, 0);
    u_host.rd(8'h13, d);
    chk("tilt mask", d, 8'h00);
    chk("tilt quiet", pin, 1'b0);
    $display("test tilt done");
    final_report();
  end
endmodule : tb
